/* core/uart_serial_port.sv */
`timescale 1ns/1ps
module uart_serial_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire uart_serial_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Baud sources
  input wire uart_serial_pkg::baud_src_s baud_src,
  // Line pins
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  output logic serial_in_pin_out,
  output logic serial_in_pin_oe,
  // Interrupt
  output logic irq
);

  // ***********************************************
  // State
  // ***********************************************
  typedef struct packed {
    uart_serial_pkg::serial_control_s ctrl;
    uart_serial_pkg::tx_state_e tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_count;
    logic [3:0] tx_sub;
    uart_serial_pkg::rx_state_e rx_state;
    logic [1:0] rx_sync;
    logic rx_prev;
    logic [9:0] rx_shift;
    logic [3:0] rx_count;
    logic [3:0] rx_sub;
    logic [7:0] rx_buffer;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic [7:0] rdata;
    logic line_out;
    logic data_oe;
  } state_s;

  state_s cur;
  state_s next_cur;

  uart_serial_pkg::mode_e mode;
  logic tx_tick;
  logic rx_tick;
  logic shift_tick;

  assign mode = uart_serial_pkg::mode_e'({cur.ctrl.mode_select_high,
                                          cur.ctrl.mode_select_low});

  // ***********************************************
  // Baud enables
  // ***********************************************
  baud_tick_gen u_baud (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .mode(mode),
    .src(baud_src),
    .tx_tick(tx_tick),
    .rx_tick(rx_tick),
    .shift_tick(shift_tick)
  );

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    logic rx_in;
    logic data_wr;
    logic tx_event;
    logic rx_event;
    logic [3:0] tx_bits;
    logic [3:0] rx_bits;
    logic [7:0] rx_byte;
    logic rx_ninth;
    logic accept;
    rx_in = cur.rx_sync[1];
    data_wr = 1'b0;
    tx_event = 1'b0;
    rx_event = 1'b0;
    tx_bits = 4'(uart_serial_pkg::FRAME9_BITS);
    rx_bits = 4'(uart_serial_pkg::FRAME9_BITS - 1);
    rx_byte = cur.rx_shift[7:0];
    rx_ninth = cur.rx_shift[8];
    accept = 1'b0;
    next_cur = cur;
    // Only the second stage feeds logic
    next_cur.rx_sync = {cur.rx_sync[0], serial_in_pin};
    next_cur.rx_prev = rx_in;
    next_cur.rdata = uart_serial_pkg::UNMAPPED_READ;

    if (mode == uart_serial_pkg::MODE_UART8) begin
      tx_bits = 4'(uart_serial_pkg::FRAME8_BITS);
      rx_bits = 4'(uart_serial_pkg::FRAME8_BITS - 1);
    end

    // ***********************************************
    // Register writes
    // ***********************************************
    if (reg_req.wr) begin
      case (reg_req.addr)
        uart_serial_pkg::SERIAL_CONTROL_ADDR: begin
          // Multiproc enable writable at any time
          next_cur.ctrl = uart_serial_pkg::serial_control_s'(
            reg_req.wdata);
        end
        uart_serial_pkg::SERIAL_DATA_ADDR: begin
          data_wr = 1'b1;
        end
        uart_serial_pkg::IRQ_STATUS_ADDR: begin
          next_cur.irq_status = cur.irq_status &
            ~reg_req.wdata[uart_serial_pkg::IRQ_WIDTH-1:0];
        end
        uart_serial_pkg::IRQ_MASK_ADDR: begin
          next_cur.irq_mask =
            reg_req.wdata[uart_serial_pkg::IRQ_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end

    // ***********************************************
    // Register reads, data valid next cycle
    // ***********************************************
    if (reg_req.rd) begin
      case (reg_req.addr)
        uart_serial_pkg::SERIAL_CONTROL_ADDR: begin
          next_cur.rdata = cur.ctrl;
        end
        uart_serial_pkg::SERIAL_DATA_ADDR: begin
          next_cur.rdata = cur.rx_buffer;
        end
        uart_serial_pkg::IRQ_STATUS_ADDR: begin
          next_cur.rdata = {6'h00, cur.irq_status};
        end
        uart_serial_pkg::IRQ_MASK_ADDR: begin
          next_cur.rdata = {6'h00, cur.irq_mask};
        end
        default: begin
          next_cur.rdata = uart_serial_pkg::UNMAPPED_READ;
        end
      endcase
    end

    // ***********************************************
    // Transmitter
    // ***********************************************
    case (cur.tx_state)
      uart_serial_pkg::TX_IDLE: begin
        // Writes while busy are dropped to keep frames intact
        if (data_wr && mode == uart_serial_pkg::MODE_SHIFT) begin
          // Shift mode shares the data pin with the receiver
          if (!cur.ctrl.tx_done_flag &&
              cur.rx_state == uart_serial_pkg::RX_IDLE) begin
            next_cur.tx_state = uart_serial_pkg::TX_SHIFT;
            next_cur.tx_shift = {3'h7, reg_req.wdata};
            next_cur.tx_count = 4'h0;
            next_cur.data_oe = ~reg_req.wdata[0];
          end
        end else if (data_wr) begin
          next_cur.tx_state = uart_serial_pkg::TX_ASYNC;
          next_cur.tx_shift = {1'b1,
            cur.ctrl.tx_ninth_bit | (mode == uart_serial_pkg::MODE_UART8),
            reg_req.wdata, 1'b0};
          next_cur.tx_count = 4'h0;
          next_cur.tx_sub = 4'h0;
          next_cur.line_out = 1'b0;
        end
      end
      uart_serial_pkg::TX_ASYNC: begin
        if (tx_tick) begin
          next_cur.tx_sub = cur.tx_sub + 4'h1;
          if (cur.tx_sub == 4'(uart_serial_pkg::OVERSAMPLE - 1)) begin
            next_cur.tx_shift = {1'b1, cur.tx_shift[10:1]};
            next_cur.tx_count = cur.tx_count + 4'h1;
            next_cur.line_out = cur.tx_shift[1];
            if (cur.tx_count + 4'h1 == tx_bits) begin
              next_cur.tx_state = uart_serial_pkg::TX_IDLE;
              next_cur.line_out = 1'b1;
              tx_event = 1'b1;
            end
          end
        end
      end
      uart_serial_pkg::TX_SHIFT: begin
        if (shift_tick) begin
          // Falling edge holds data; rising edge moves it on
          next_cur.line_out = ~cur.line_out;
          if (!cur.line_out) begin
            next_cur.tx_count = cur.tx_count + 4'h1;
            next_cur.tx_shift = {1'b1, cur.tx_shift[10:1]};
            next_cur.data_oe = ~cur.tx_shift[1];
            if (cur.tx_count == 4'(uart_serial_pkg::SHIFT_BITS - 1)) begin
              next_cur.tx_state = uart_serial_pkg::TX_IDLE;
              next_cur.data_oe = 1'b0;
              tx_event = 1'b1;
            end
          end
        end
      end
      default: begin
        next_cur.tx_state = uart_serial_pkg::TX_IDLE;
      end
    endcase

    // ***********************************************
    // Receiver, runs beside the transmitter except in shift mode
    // ***********************************************
    case (cur.rx_state)
      uart_serial_pkg::RX_IDLE: begin
        if (mode == uart_serial_pkg::MODE_SHIFT) begin
          if (cur.ctrl.rx_enable && !cur.ctrl.rx_done_flag &&
              cur.tx_state == uart_serial_pkg::TX_IDLE) begin
            next_cur.rx_state = uart_serial_pkg::RX_SHIFT;
            next_cur.rx_count = 4'h0;
          end
        end else if (cur.ctrl.rx_enable && cur.rx_prev && !rx_in) begin
          next_cur.rx_state = uart_serial_pkg::RX_START;
          next_cur.rx_sub = 4'h0;
        end
      end
      uart_serial_pkg::RX_START: begin
        if (rx_tick) begin
          next_cur.rx_sub = cur.rx_sub + 4'h1;
          if (cur.rx_sub == 4'(uart_serial_pkg::START_MID - 1)) begin
            // A glitch shorter than half a bit is not a start
            next_cur.rx_state = rx_in ? uart_serial_pkg::RX_IDLE :
                                        uart_serial_pkg::RX_DATA;
            next_cur.rx_sub = 4'h0;
            next_cur.rx_count = 4'h0;
          end
        end
      end
      uart_serial_pkg::RX_DATA: begin
        if (rx_tick) begin
          next_cur.rx_sub = cur.rx_sub + 4'h1;
          if (cur.rx_sub == 4'(uart_serial_pkg::OVERSAMPLE - 1)) begin
            next_cur.rx_shift = {rx_in, cur.rx_shift[9:1]};
            next_cur.rx_count = cur.rx_count + 4'h1;
            if (cur.rx_count + 4'h1 == rx_bits) begin
              next_cur.rx_state = uart_serial_pkg::RX_IDLE;
              rx_event = 1'b1;
            end
          end
        end
      end
      uart_serial_pkg::RX_SHIFT: begin
        next_cur.data_oe = 1'b0;
        if (shift_tick) begin
          next_cur.line_out = ~cur.line_out;
          if (cur.line_out) begin
            // Sample while the far end holds data steady
            next_cur.rx_shift = {rx_in, cur.rx_shift[9:1]};
          end else begin
            next_cur.rx_count = cur.rx_count + 4'h1;
            if (cur.rx_count == 4'(uart_serial_pkg::SHIFT_BITS - 1)) begin
              next_cur.rx_state = uart_serial_pkg::RX_IDLE;
              rx_event = 1'b1;
            end
          end
        end
      end
      default: begin
        next_cur.rx_state = uart_serial_pkg::RX_IDLE;
      end
    endcase

    // ***********************************************
    // Frame completion, evaluated on the final shift
    // ***********************************************
    if (rx_event) begin
      case (mode)
        uart_serial_pkg::MODE_SHIFT: begin
          rx_byte = next_cur.rx_shift[9:2];
          rx_ninth = cur.ctrl.rx_ninth_bit;
        end
        uart_serial_pkg::MODE_UART8: begin
          rx_byte = next_cur.rx_shift[8:1];
          rx_ninth = next_cur.rx_shift[9];
        end
        default: begin
          rx_byte = next_cur.rx_shift[7:0];
          rx_ninth = next_cur.rx_shift[8];
        end
      endcase
      // An unread byte is kept; the newer one is lost
      accept = !next_cur.ctrl.rx_done_flag &&
               (mode == uart_serial_pkg::MODE_SHIFT ||
                !cur.ctrl.multiproc_enable || rx_ninth);
      if (accept) begin
        next_cur.rx_buffer = rx_byte;
        next_cur.ctrl.rx_ninth_bit = rx_ninth;
        next_cur.ctrl.rx_done_flag = 1'b1;
        next_cur.irq_status[uart_serial_pkg::IRQ_RX_BIT] = 1'b1;
      end
    end

    // Hardware set wins over a same-cycle clear
    if (tx_event) begin
      next_cur.ctrl.tx_done_flag = 1'b1;
      next_cur.irq_status[uart_serial_pkg::IRQ_TX_BIT] = 1'b1;
    end

    next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
  end

  // ***********************************************
  // Registers
  // ***********************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur.ctrl <= uart_serial_pkg::serial_control_s'(
        uart_serial_pkg::CONTROL_RESET);
      cur.tx_state <= uart_serial_pkg::TX_IDLE;
      cur.tx_shift <= 11'h7ff;
      cur.tx_count <= 4'h0;
      cur.tx_sub <= 4'h0;
      cur.rx_state <= uart_serial_pkg::RX_IDLE;
      cur.rx_sync <= 2'h3;
      cur.rx_prev <= 1'b1;
      cur.rx_shift <= 10'h000;
      cur.rx_count <= 4'h0;
      cur.rx_sub <= 4'h0;
      cur.rx_buffer <= uart_serial_pkg::DATA_RESET;
      cur.irq_status <= uart_serial_pkg::IRQ_RESET;
      cur.irq_mask <= uart_serial_pkg::IRQ_RESET;
      cur.irq <= 1'b0;
      cur.rdata <= uart_serial_pkg::UNMAPPED_READ;
      cur.line_out <= 1'b1;
      cur.data_oe <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign reg_rdata = cur.rdata;
  assign serial_out_pin = cur.line_out;
  // Open drain: only ever pulls low
  assign serial_in_pin_out = 1'b0;
  assign serial_in_pin_oe = cur.data_oe;
  assign irq = cur.irq;

endmodule

/* core/uart_serial_pkg.sv */
package uart_serial_pkg;

  // ***********************************************
  // Register map
  // ***********************************************
  localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
  localparam logic [7:0] SERIAL_DATA_ADDR = 8'h99;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h9a;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h9b;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Interrupt status and mask layout
  localparam int IRQ_WIDTH = 2;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int SHIFT_DIV = 12;
  localparam int SHIFT_HALF = SHIFT_DIV / 2;
  localparam int OVERSAMPLE = 16;
  localparam int MODE2_DIV_FAST = 32;
  localparam int MODE2_DIV_SLOW = 64;
  localparam int MODE2_TICK_FAST = MODE2_DIV_FAST / OVERSAMPLE;
  localparam int MODE2_TICK_SLOW = MODE2_DIV_SLOW / OVERSAMPLE;
  localparam int START_MID = OVERSAMPLE / 2;
  localparam int SHIFT_BITS = 8;
  localparam int FRAME8_BITS = 10;
  localparam int FRAME9_BITS = 11;

  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9_FIXED = 2'b10,
    MODE_UART9_VAR = 2'b11
  } mode_e;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } serial_control_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic timer1_overflow;
    logic timer2_overflow;
    logic baud_double;
    logic timer2_tx_clock_select;
    logic timer2_rx_clock_select;
  } baud_src_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_ASYNC = 3'b010,
    TX_SHIFT = 3'b100
  } tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_SHIFT = 4'b1000
  } rx_state_e;

endpackage

/* core/baud_tick_gen.sv */
`timescale 1ns/1ps
module baud_tick_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Rate selection
  input wire uart_serial_pkg::mode_e mode,
  input wire uart_serial_pkg::baud_src_s src,
  // Enables
  output logic tx_tick,
  output logic rx_tick,
  output logic shift_tick
);

  typedef struct packed {
    logic [5:0] div;
    logic t1_half;
    logic tx_tick;
    logic rx_tick;
    logic shift_tick;
  } state_s;

  state_s cur;
  state_s next_cur;

  always_comb begin
    logic [5:0] limit;
    logic wrap;
    logic t1_rate;
    limit = 6'(uart_serial_pkg::SHIFT_HALF - 1);
    wrap = 1'b0;
    t1_rate = 1'b0;
    next_cur = cur;
    next_cur.shift_tick = 1'b0;
    next_cur.tx_tick = 1'b0;
    next_cur.rx_tick = 1'b0;
    // Shift clock half period, core clock / 12 per full period
    if (mode == uart_serial_pkg::MODE_UART9_FIXED) begin
      limit = src.baud_double ?
        6'(uart_serial_pkg::MODE2_TICK_FAST - 1) :
        6'(uart_serial_pkg::MODE2_TICK_SLOW - 1);
    end
    wrap = (cur.div >= limit);
    next_cur.div = wrap ? 6'h00 : cur.div + 6'h01;
    if (src.timer1_overflow) begin
      next_cur.t1_half = ~cur.t1_half;
    end
    // Half rate passes every second overflow
    t1_rate = src.timer1_overflow & (src.baud_double | cur.t1_half);
    case (mode)
      uart_serial_pkg::MODE_SHIFT: begin
        next_cur.shift_tick = wrap;
      end
      uart_serial_pkg::MODE_UART9_FIXED: begin
        next_cur.tx_tick = wrap;
        next_cur.rx_tick = wrap;
      end
      default: begin
        next_cur.tx_tick = src.timer2_tx_clock_select ?
          src.timer2_overflow : t1_rate;
        next_cur.rx_tick = src.timer2_rx_clock_select ?
          src.timer2_overflow : t1_rate;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tx_tick = cur.tx_tick;
  assign rx_tick = cur.rx_tick;
  assign shift_tick = cur.shift_tick;

endmodule

/* tb/uart_serial_port_properties.sv */
`timescale 1ns/1ps
module uart_serial_port_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire uart_serial_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  // Baud sources
  input wire uart_serial_pkg::baud_src_s baud_src,
  // Line pins and interrupt
  input wire logic serial_out_pin,
  input wire logic serial_in_pin,
  input wire logic serial_in_pin_out,
  input wire logic serial_in_pin_oe,
  input wire logic irq
);
  // ****************************
  // Shadow of software writes
  // ****************************
  logic [7:0] ctl_q;
  logic [1:0] msk_q;
  logic sync_mode;
  logic mapped;
  assign sync_mode = ctl_q[7:6] == 2'h0;
  assign mapped = reg_req.addr[7:2] == 6'h26;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= 8'h00;
      msk_q <= 2'h0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == uart_serial_pkg::SERIAL_CONTROL_ADDR) begin
        ctl_q <= reg_req.wdata;
      end
      if (reg_req.addr == uart_serial_pkg::IRQ_MASK_ADDR) begin
        msk_q <= reg_req.wdata[1:0];
      end
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ****************************
  // Checks
  // ****************************
  chk_rdata_idle: assert property (
    !reg_req.rd |=> reg_rdata == 8'h00) else $error("stray read data");
  chk_unmapped_read: assert property (
    reg_req.rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_readback: assert property (
    reg_req.rd && reg_req.addr == uart_serial_pkg::SERIAL_CONTROL_ADDR
    |=> reg_rdata[7:3] == ctl_q[7:3]) else $error("control readback");
  chk_mask_readback: assert property (
    reg_req.rd && reg_req.addr == uart_serial_pkg::IRQ_MASK_ADDR
    |=> reg_rdata == {6'h00, msk_q}) else $error("mask readback");
  chk_irq_masked: assert property (
    (msk_q == 2'h0)[*3] |-> !irq) else $error("irq while masked");
  chk_open_drain: assert property (
    !serial_in_pin_out) else $error("data pin driven high");
  chk_oe_on_rise: assert property (
    sync_mode && $changed(serial_in_pin_oe) |-> serial_out_pin)
    else $error("data changed while shift clock low");
  chk_shift_low: assert property (
    sync_mode && $fell(serial_out_pin)
    |-> (!serial_out_pin)[*6] ##1 serial_out_pin)
    else $error("shift clock low phase not six cycles");
  chk_async_no_drive: assert property (
    !sync_mode |-> !serial_in_pin_oe) else $error("data pin driven");
  chk_bit_low_width: assert property (
    !sync_mode && $fell(serial_out_pin) |-> (!serial_out_pin)[*8])
    else $error("async low cell too short");
  chk_bit_high_width: assert property (
    !sync_mode && $rose(serial_out_pin) |-> serial_out_pin[*8])
    else $error("async high cell too short");
  cover property (sync_mode && $fell(serial_out_pin));
  cover property ($rose(irq));
  cover property (reg_req.rd && !mapped);
  cover property ($rose(serial_in_pin_oe));
endmodule

bind uart_serial_port uart_serial_port_properties u_props (
  .clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .baud_src(baud_src),
  .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin),
  .serial_in_pin_out(serial_in_pin_out),
  .serial_in_pin_oe(serial_in_pin_oe), .irq(irq));

/* tb/uart_serial_node.sv */
`timescale 1ns/1ps
module uart_serial_node (
  // Clock
  input wire logic clk_sys,
  // Line pins
  input wire logic shift_clk,
  output logic line
);
  logic async_line = 1'b1;
  logic m0_active = 1'b0;
  logic [7:0] m0_data = 8'h00;
  logic [2:0] m0_cnt = 3'h0;
  // Released line follows the async sender, which idles high
  assign line = m0_active ? m0_data[0] : async_line;
  // ****************************
  // Async frame sender
  // ****************************
  task automatic send(input logic [10:0] fr, input int nb, input int per);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_sys);
      async_line <= fr[i];
      repeat (per - 1) @(posedge clk_sys);
    end
  endtask
  // ****************************
  // Shift register source
  // ****************************
  task automatic load_shift(input logic [7:0] d);
    m0_data = d;
    m0_cnt = 3'h0;
    m0_active = 1'b1;
  endtask
  always @(posedge shift_clk) begin
    if (m0_active) begin
      m0_data <= m0_data >> 1;
      m0_cnt <= m0_cnt + 3'h1;
      m0_active <= m0_cnt != 3'h7;
    end
  end
endmodule

/* tb/uart0_serial_port_tb.sv */
`timescale 1ns/1ps
module uart0_serial_port_tb;
  localparam logic [7:0] a_ctl = uart_serial_pkg::SERIAL_CONTROL_ADDR;
  localparam logic [7:0] a_dat = uart_serial_pkg::SERIAL_DATA_ADDR;
  localparam logic [7:0] a_sts = uart_serial_pkg::IRQ_STATUS_ADDR;
  localparam logic [7:0] a_msk = uart_serial_pkg::IRQ_MASK_ADDR;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  uart_serial_pkg::reg_req_s reg_req = '0;
  uart_serial_pkg::baud_src_s baud_src;
  logic t1_ovf = 1'b0;
  logic t2_ovf = 1'b0;
  logic bd = 1'b0;
  logic t2_sel = 1'b0;
  logic [1:0] div = 2'h0;
  logic [7:0] reg_rdata;
  logic serial_out_pin;
  logic serial_in_pin;
  logic serial_in_pin_oe;
  logic irq;
  logic line;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  assign baud_src = '{t1_ovf, t2_ovf, bd, t2_sel, t2_sel};
  assign serial_in_pin = serial_in_pin_oe ? 1'b0 : line;
  always #12.5 clk_sys = ~clk_sys;
  // Timer 1 overflows every 2 clocks, timer 2 every 4
  always @(posedge clk_sys) begin
    div <= div + 2'h1;
    t1_ovf <= div[0];
    t2_ovf <= div == 2'h3;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  uart_serial_port u_uart_serial_port (.clk_sys(clk_sys),
    .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .baud_src(baud_src), .serial_out_pin(serial_out_pin),
    .serial_in_pin(serial_in_pin), .serial_in_pin_out(),
    .serial_in_pin_oe(serial_in_pin_oe), .irq(irq));
  uart_serial_node u_uart_serial_node (.clk_sys(clk_sys),
    .shift_clk(serial_out_pin), .line(line));
  // ****************************
  // Helpers
  // ****************************
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    reg_req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clk_sys);
  endtask
  task automatic wreg(input logic [7:0] a, d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    bus(1'b0, 1'b1, a, 8'h00);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    @(negedge clk_sys);
    v = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic wait_fall(output int n);
    logic prev;
    prev = serial_out_pin;
    for (n = 1; n < 100; n++) begin
      @(posedge clk_sys);
      #1;
      if (prev && !serial_out_pin) break;
      prev = serial_out_pin;
    end
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_regs();
    logic [7:0] v;
    rreg(a_ctl, v);
    chk(v, 8'h00);
    wreg(8'h9c, 8'hff);
    rreg(8'h9c, v);
    chk(v, 8'h00);
    bus(1'b1, 1'b0, a_ctl, 8'hf8);
    rreg(a_ctl, v);
    chk(v, 8'hf8);
    bus(1'b1, 1'b0, a_msk, 8'h03);
    rreg(a_msk, v);
    chk(v, 8'h03);
    wreg(a_msk, 8'h00);
  endtask
  task automatic t_tx(input logic [7:0] c, d, input int nb, per,
                      input logic b, s);
    logic [10:0] fr;
    logic [7:0] v;
    fr = {1'b1, c[3] | (nb == 10), d, 1'b0};
    bd <= b;
    t2_sel <= s;
    wreg(a_ctl, c);
    wreg(a_dat, d);
    repeat (per / 2 - 2) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      #1;
      chk({7'h0, serial_out_pin}, {7'h0, fr[i]});
      repeat (per) @(posedge clk_sys);
    end
    rreg(a_ctl, v);
    chk(v & 8'h03, 8'h02);
  endtask
  task automatic t_irq();
    logic [7:0] v;
    rreg(a_sts, v);
    chk(v, 8'h02);
    chk({7'h0, irq}, 8'h00);
    wreg(a_msk, 8'h02);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h0, irq}, 8'h01);
    wreg(a_sts, 8'h02);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h0, irq}, 8'h00);
  endtask
  task automatic t_rx(input logic [7:0] c, d, input logic nin, acc,
                      input logic [7:0] keep);
    logic [7:0] v;
    bd <= 1'b1;
    wreg(a_ctl, c);
    if (c[3]) wreg(a_dat, 8'h55);
    u_uart_serial_node.send({1'b1, nin, d, 1'b0}, 11, 32);
    repeat (48) @(posedge clk_sys);
    rreg(a_ctl, v);
    chk(v & 8'h07, {5'h0, acc & nin, c[3], acc});
    rreg(a_dat, v);
    chk(v, acc ? d : keep);
  endtask
  task automatic t_m0tx();
    logic [7:0] v;
    logic [7:0] got;
    int n;
    wreg(a_ctl, 8'h00);
    wreg(a_dat, 8'h5a);
    for (int i = 0; i < 8; i++) begin
      wait_fall(n);
      got[i] = serial_in_pin;
      if (i > 0) chk(n[7:0], 8'h0c);
    end
    chk(got, 8'h5a);
    repeat (12) @(posedge clk_sys);
    rreg(a_ctl, v);
    chk(v & 8'h03, 8'h02);
    wreg(a_dat, 8'ha5);
    wait_fall(n);
    chk(n[7:0], 8'h64);
  endtask
  task automatic t_m0rx();
    logic [7:0] v;
    int n;
    wreg(a_sts, 8'h03);
    u_uart_serial_node.load_shift(8'hc3);
    wreg(a_ctl, 8'h10);
    for (int i = 0; i < 8; i++) wait_fall(n);
    repeat (24) @(posedge clk_sys);
    rreg(a_ctl, v);
    chk(v & 8'h03, 8'h01);
    rreg(a_dat, v);
    chk(v, 8'hc3);
    rreg(a_sts, v);
    chk(v & 8'h01, 8'h01);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_tx(8'h40, 8'ha5, 10, 32, 1'b1, 1'b0);
    t_irq();
    t_tx(8'h88, 8'h3c, 11, 64, 1'b0, 1'b0);
    t_tx(8'hc0, 8'h81, 11, 64, 1'b0, 1'b1);
    t_tx(8'h40, 8'h5a, 10, 64, 1'b0, 1'b0);
    t_rx(8'h98, 8'h96, 1'b1, 1'b1, 8'h00);
    t_rx(8'hb0, 8'h11, 1'b0, 1'b0, 8'h96);
    t_rx(8'hb0, 8'h42, 1'b1, 1'b1, 8'h00);
    t_rx(8'h90, 8'h24, 1'b0, 1'b1, 8'h00);
    t_m0tx();
    t_m0rx();
    end_sim();
  end
endmodule
